/* hw/sdc_pkg.sv */
// What this block does
// - Sixteen-bit checksum register, readable and writable
// - Seven-bit mode keeps checksum in bits 6:0
// - Data read returns byte, empties receive FIFO
// - Data write starts transfer of programmed bit length when no frame or DMA block runs
// - Transmit base address sixteen bits, resets zero
// - Transmit count eleven bits, resets zero
// - Receive base address sixteen bits, resets zero
// - Receive count eleven bits, resets zero
// - Two-bit select picks checksum polynomial
// - Checksum clear presets ones, reads zero
// - Block transfer completion sets interrupt flag
`default_nettype none
package sdc_pkg;
  // ==========================================================
  // Register indices (printed offsets are not word multiples)
  localparam logic [15:0] IDX_DATA     = 16'hc0d6;
  localparam logic [15:0] IDX_TX_BASE  = 16'hc0d8;
  localparam logic [15:0] IDX_TX_LEN   = 16'hc0da;
  localparam logic [15:0] IDX_RX_BASE  = 16'hc0dc;
  localparam logic [15:0] IDX_RX_LEN   = 16'hc0de;
  localparam logic [15:0] IDX_CRC_VAL  = 16'hc0d4;
  localparam logic [15:0] IDX_CTRL     = 16'hc0e8;
  localparam logic [15:0] IDX_STATUS   = 16'hc0ea;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hc0ec;
  localparam logic [15:0] IDX_DMA_CMD  = 16'hc0ee;
  // ==========================================================
  // Control register fields
  localparam int CTRL_LEN_LSB  = 0;  // Transmit bit length - 1, 3 bits
  localparam int CTRL_POLY_LSB = 4;  // Polynomial select, 2 bits
  localparam int CTRL_CRC_EN   = 6;
  localparam int CTRL_CRC_CLR  = 7;  // Self clearing
  localparam int CTRL_RX_CRC   = 8;
  localparam int CTRL_DIV_LSB  = 9;  // Serial clock half period divider, 4 bits
  // Status / mask bits
  localparam int ST_RX   = 0;
  localparam int ST_TX   = 1;
  localparam int ST_BLK  = 2;
  localparam int ST_OVF  = 3;
  localparam int ST_BUSY = 4;
  // DMA command bits
  localparam int CMD_TX_GO = 0;
  localparam int CMD_RX_GO = 1;
  // ==========================================================
  // Reset values and encodings
  localparam logic [15:0] CRC_RESET   = 16'hffff;
  localparam logic [15:0] CTRL_RESET  = 16'h0207;
  localparam logic [1:0]  POLY_CCITT  = 2'h0;
  localparam logic [1:0]  POLY_SEVEN  = 2'h1;
  localparam logic [1:0]  POLY_ALT    = 2'h2;
  localparam logic [15:0] TAPS_CCITT  = 16'h1021;
  localparam logic [15:0] TAPS_SEVEN  = 16'h0009;
  localparam logic [15:0] TAPS_ALT    = 16'h8005;
  localparam int          FIFO_DEPTH  = 8;
  typedef enum logic [1:0] {SDC_IDLE, SDC_LOW, SDC_HIGH} sdc_shift_t;
  typedef enum logic [1:0] {SDC_DIDLE, SDC_DREQ, SDC_DSHIFT} sdc_dma_t;
endpackage : sdc_pkg
`default_nettype wire

/* hw/sdc_crc.sv */
`default_nettype none
// ==========================================================
// Serial checksum engine, one bit per step
module sdc_crc (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [1:0]  poly_sel,
  input  wire logic        step,
  input  wire logic        bit_in,
  input  wire logic        preset,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  output logic      [15:0] crc_q
);
  // Feedback tap from the current width's top bit
  wire        seven  = (poly_sel == sdc_pkg::POLY_SEVEN);
  wire        fb     = bit_in ^ (seven ? crc_q[6] : crc_q[15]);
  wire [15:0] taps   = (poly_sel == sdc_pkg::POLY_SEVEN) ? sdc_pkg::TAPS_SEVEN :
                       (poly_sel == sdc_pkg::POLY_ALT)   ? sdc_pkg::TAPS_ALT :
                       sdc_pkg::TAPS_CCITT;
  wire [15:0] shl    = {crc_q[14:0], 1'b0} ^ (fb ? taps : 16'h0000);
  wire [15:0] next_v = seven ? {9'h000, shl[6:0]} : shl;

  // Preset beats load beats step
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) crc_q <= sdc_pkg::CRC_RESET;
    else if (preset) crc_q <= sdc_pkg::CRC_RESET;
    else if (load) crc_q <= load_val;
    else if (step) crc_q <= next_v;
  end
endmodule : sdc_crc
`default_nettype wire

/* hw/sdc_fifo.sv */
`default_nettype none
// ==========================================================
// Receive byte FIFO; flush empties it whole
module sdc_fifo #(
  parameter int DEPTH = sdc_pkg::FIFO_DEPTH
) (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       push,
  input  wire logic [7:0] push_data,
  input  wire logic       pop,
  input  wire logic       flush,
  output logic      [7:0] head,
  output logic            empty,
  output logic            full
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
    $error("DEPTH must be power of two");
  end
  logic [7:0]  mem [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  assign empty = (wp_q == rp_q);
  assign full  = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
  assign head  = mem[rp_q[AW-1:0]];

  // Storage has no reset; contents are undefined until written
  always_ff @(posedge mclk) begin
    if (push && !full) mem[wp_q[AW-1:0]] <= push_data;
  end

  // Pointers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (flush) begin
      rp_q <= wp_q + (AW+1)'(push && !full);
      wp_q <= wp_q + (AW+1)'(push && !full);
    end else begin
      if (push && !full) wp_q <= wp_q + 1'b1;
      if (pop && !empty) rp_q <= rp_q + 1'b1;
    end
  end
endmodule : sdc_fifo
`default_nettype wire

/* hw/sdc_top.sv */
// The APB register port was decided locally.
`default_nettype none
// ==========================================================
// SPI data path: byte register, receive FIFO, block DMA, checksum
module sdc_top (
  input  wire logic        mclk,
  input  wire logic        resetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // SPI master pins
  output logic             spi_sck,
  output logic             spi_mosi,
  input  wire logic        spi_miso,
  output logic             spi_ssn,
  // DMA memory port
  output logic             mem_req,
  output logic             mem_we,
  output logic      [15:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_ack,
  output logic             irq
);
  // ==========================================================
  // APB decode; byte address is four times the register index
  logic        pready_q, pslverr_q;
  function automatic logic hit(input logic [31:0] a, input logic [15:0] idx);
    hit = (a == {14'h0000, idx, 2'b00});
  endfunction : hit
  wire       acc      = psel && penable && !pready_q;
  wire       wr       = acc && pwrite && pstrb[0];
  wire       rd       = acc && !pwrite;
  wire       h_data   = hit(paddr, sdc_pkg::IDX_DATA);
  wire       h_txb    = hit(paddr, sdc_pkg::IDX_TX_BASE);
  wire       h_txl    = hit(paddr, sdc_pkg::IDX_TX_LEN);
  wire       h_rxb    = hit(paddr, sdc_pkg::IDX_RX_BASE);
  wire       h_rxl    = hit(paddr, sdc_pkg::IDX_RX_LEN);
  wire       h_crc    = hit(paddr, sdc_pkg::IDX_CRC_VAL);
  wire       h_ctrl   = hit(paddr, sdc_pkg::IDX_CTRL);
  wire       h_stat   = hit(paddr, sdc_pkg::IDX_STATUS);
  wire       h_mask   = hit(paddr, sdc_pkg::IDX_IRQ_MASK);
  wire       h_cmd    = hit(paddr, sdc_pkg::IDX_DMA_CMD);
  wire       mapped   = h_data | h_txb | h_txl | h_rxb | h_rxl | h_crc | h_ctrl |
                        h_stat | h_mask | h_cmd;

  // ==========================================================
  // Registers
  logic [31:0] prdata_q;
  logic [15:0] tx_base_q, rx_base_q, ctrl_q;
  logic [10:0] tx_len_q, rx_len_q;
  logic [4:0]  stat_q, mask_q;
  logic        irq_q;
  logic [7:0]  tx_byte_q;
  logic        pio_go_q;
  logic [15:0] crc_val;
  logic [7:0]  fifo_head;
  logic        fifo_empty, fifo_full;

  wire [2:0] bit_len  = ctrl_q[sdc_pkg::CTRL_LEN_LSB +: 3];
  wire [1:0] poly_sel = ctrl_q[sdc_pkg::CTRL_POLY_LSB +: 2];
  wire [3:0] div      = ctrl_q[sdc_pkg::CTRL_DIV_LSB +: 4];

  // ==========================================================
  // Pin synchroniser for the returning data line
  logic miso_s1_q, miso_s2_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) {miso_s1_q, miso_s2_q} <= 2'b00;
    else {miso_s2_q, miso_s1_q} <= {miso_s1_q, spi_miso};
  end

  // ==========================================================
  // Serial shifter: mode 0, MSB first, programmable length
  sdc_pkg::sdc_shift_t sh_q;
  logic [3:0] divcnt_q;
  logic [2:0] bitcnt_q;
  logic [7:0] sh_tx_q, sh_rx_q;
  logic       sck_q, ssn_q, mosi_q, done_q, sh_dma_q;
  wire        tick     = (divcnt_q == div);
  wire        sh_idle  = (sh_q == sdc_pkg::SDC_IDLE);
  wire        last_bit = (bitcnt_q == bit_len);
  wire        sample   = (sh_q == sdc_pkg::SDC_LOW) && tick;
  wire        crc_bit  = ctrl_q[sdc_pkg::CTRL_RX_CRC] ? miso_s2_q : sh_tx_q[7];
  wire [7:0]  rx_next  = {sh_rx_q[6:0], miso_s2_q};

  // ==========================================================
  // DMA engine; one shifter frame per byte
  sdc_pkg::sdc_dma_t dma_q;
  logic        dma_tx_q;
  logic [15:0] dma_addr_q;
  logic [10:0] dma_left_q;
  logic [7:0]  dma_byte_q;
  logic        dma_start_q;
  logic        store_q;
  wire         cmd_tx   = wr && h_cmd && pwdata[sdc_pkg::CMD_TX_GO];
  wire         cmd_rx   = wr && h_cmd && pwdata[sdc_pkg::CMD_RX_GO] && !cmd_tx;
  wire         dma_idle = (dma_q == sdc_pkg::SDC_DIDLE);
  wire         pio_wr   = wr && h_data && dma_idle;
  // A byte counts as moved once shifted (transmit) or stored (receive)
  wire         dma_step = (dma_q == sdc_pkg::SDC_DSHIFT) &&
                          (dma_tx_q ? done_q : (store_q && mem_ack));
  wire         blk_done = dma_step && (dma_left_q == 11'h001);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sh_q     <= sdc_pkg::SDC_IDLE;
      divcnt_q <= 4'h0;
      bitcnt_q <= 3'h0;
      sh_tx_q  <= 8'h00;
      sh_rx_q  <= 8'h00;
      sck_q    <= 1'b0;
      ssn_q    <= 1'b1;
      mosi_q   <= 1'b0;
      done_q   <= 1'b0;
      sh_dma_q <= 1'b0;
    end else begin
      done_q   <= 1'b0;
      divcnt_q <= (tick || sh_idle) ? 4'h0 : divcnt_q + 4'h1;
      case (sh_q)
        sdc_pkg::SDC_IDLE: if (pio_go_q || dma_start_q) begin
          sh_q     <= sdc_pkg::SDC_LOW;
          sh_dma_q <= dma_start_q;
          sh_tx_q  <= dma_start_q ? dma_byte_q : tx_byte_q;
          mosi_q   <= dma_start_q ? dma_byte_q[7] : tx_byte_q[7];
          ssn_q    <= 1'b0;
          bitcnt_q <= 3'h0;
        end
        sdc_pkg::SDC_LOW: if (tick) begin
          sck_q   <= 1'b1;
          sh_rx_q <= rx_next;
          sh_q    <= sdc_pkg::SDC_HIGH;
        end
        sdc_pkg::SDC_HIGH: if (tick) begin
          sck_q <= 1'b0;
          if (last_bit) begin
            sh_q   <= sdc_pkg::SDC_IDLE;
            ssn_q  <= 1'b1;
            done_q <= 1'b1;
          end else begin
            sh_q     <= sdc_pkg::SDC_LOW;
            bitcnt_q <= bitcnt_q + 3'h1;
            sh_tx_q  <= {sh_tx_q[6:0], 1'b0};
            mosi_q   <= sh_tx_q[6];
          end
        end
        default: sh_q <= sdc_pkg::SDC_IDLE;
      endcase
    end
  end

  // DMA sequencer: fetch byte (transmit), shift, store received byte (receive), step address
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dma_q       <= sdc_pkg::SDC_DIDLE;
      dma_tx_q    <= 1'b0;
      dma_addr_q  <= 16'h0000;
      dma_left_q  <= 11'h000;
      dma_byte_q  <= 8'h00;
      dma_start_q <= 1'b0;
      store_q     <= 1'b0;
    end else begin
      dma_start_q <= 1'b0;
      // Done is a pulse, so the store request is held here until acked
      store_q <= ((dma_q == sdc_pkg::SDC_DSHIFT) && !dma_tx_q && done_q) ||
                 (store_q && !mem_ack);
      case (dma_q)
        sdc_pkg::SDC_DIDLE: if ((cmd_tx && tx_len_q != 0) || (cmd_rx && rx_len_q != 0)) begin
          dma_tx_q   <= cmd_tx;
          dma_addr_q <= cmd_tx ? tx_base_q : rx_base_q;
          dma_left_q <= cmd_tx ? tx_len_q : rx_len_q;
          dma_q      <= cmd_tx ? sdc_pkg::SDC_DREQ : sdc_pkg::SDC_DSHIFT;
          dma_byte_q <= 8'hff;
          dma_start_q <= !cmd_tx;
        end
        sdc_pkg::SDC_DREQ: if (mem_ack) begin
          dma_byte_q  <= mem_rdata;
          dma_start_q <= 1'b1;
          dma_q       <= sdc_pkg::SDC_DSHIFT;
        end
        sdc_pkg::SDC_DSHIFT: if (dma_step) begin
          dma_addr_q <= dma_addr_q + 16'h0001;
          dma_left_q <= dma_left_q - 11'h001;
          if (dma_left_q == 11'h001) dma_q <= sdc_pkg::SDC_DIDLE;
          else if (dma_tx_q) dma_q <= sdc_pkg::SDC_DREQ;
          else dma_start_q <= 1'b1;
        end
        default: dma_q <= sdc_pkg::SDC_DIDLE;
      endcase
    end
  end
  // Receive store request
  wire rx_store = store_q;

  // ==========================================================
  // Memory port outputs registered
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= 16'h0000;
      mem_wdata <= 8'h00;
    end else begin
      mem_req   <= ((dma_q == sdc_pkg::SDC_DREQ) || rx_store) && !mem_ack;
      mem_we    <= rx_store;
      mem_addr  <= dma_addr_q;
      mem_wdata <= sh_rx_q;
    end
  end

  // ==========================================================
  // Receive FIFO; filled in byte mode only, any data register read empties it
  sdc_fifo #(.DEPTH(sdc_pkg::FIFO_DEPTH)) u_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .push      (done_q && !sh_dma_q),
    .push_data (sh_rx_q),
    .pop       (1'b0),
    .flush     (rd && h_data),
    .head      (fifo_head),
    .empty     (fifo_empty),
    .full      (fifo_full)
  );

  // ==========================================================
  // Checksum engine
  sdc_crc u_crc (
    .mclk     (mclk),
    .resetn   (resetn),
    .poly_sel (poly_sel),
    .step     (sample && ctrl_q[sdc_pkg::CTRL_CRC_EN]),
    .bit_in   (crc_bit),
    .preset   (wr && h_ctrl && pwdata[sdc_pkg::CTRL_CRC_CLR]),
    .load     (wr && h_crc),
    .load_val (pwdata[15:0]),
    .crc_q    (crc_val)
  );

  // ==========================================================
  // Software registers; set beats write-one-to-clear
  wire [4:0] ev = {1'b0, done_q && !sh_dma_q && fifo_full,
                   blk_done, done_q && !sh_dma_q, done_q && !sh_dma_q};
  wire [4:0] w1c = (wr && h_stat) ? pwdata[4:0] : 5'h00;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tx_base_q <= 16'h0000;
      rx_base_q <= 16'h0000;
      tx_len_q  <= 11'h000;
      rx_len_q  <= 11'h000;
      ctrl_q    <= sdc_pkg::CTRL_RESET;
      mask_q    <= 5'h00;
      stat_q    <= 5'h00;
      tx_byte_q <= 8'h00;
      pio_go_q  <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      if (wr && h_txb) tx_base_q <= pwdata[15:0];
      if (wr && h_rxb) rx_base_q <= pwdata[15:0];
      if (wr && h_txl) tx_len_q <= pwdata[10:0];
      if (wr && h_rxl) rx_len_q <= pwdata[10:0];
      // Clear bit is never stored, so it reads zero
      if (wr && h_ctrl) ctrl_q <= pwdata[15:0] & ~(16'h0001 << sdc_pkg::CTRL_CRC_CLR);
      if (wr && h_mask) mask_q <= pwdata[4:0];
      if (pio_wr) tx_byte_q <= pwdata[7:0];
      pio_go_q <= pio_wr || (pio_go_q && !sh_idle) ? pio_wr : 1'b0;
      stat_q   <= (stat_q & ~w1c) | ev;
      irq_q    <= |((stat_q & ~w1c | ev) & mask_q);
    end
  end

  // ==========================================================
  // Read mux and single-wait APB answer
  wire [15:0] crc_rd = (poly_sel == sdc_pkg::POLY_SEVEN) ? {9'h000, crc_val[6:0]}
                                                           : crc_val;
  wire [15:0] rmux =
      h_data ? {8'h00, fifo_head} :
      h_txb  ? tx_base_q :
      h_txl  ? {5'h00, tx_len_q} :
      h_rxb  ? rx_base_q :
      h_rxl  ? {5'h00, rx_len_q} :
      h_crc  ? crc_rd :
      h_ctrl ? ctrl_q :
      h_stat ? {11'h000, !sh_idle || !dma_idle, stat_q[3:0]} :
      h_mask ? {11'h000, mask_q} : 16'h0000;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= acc;
      pslverr_q <= acc && !mapped;
      prdata_q  <= rd ? {16'h0000, rmux} : 32'h0000_0000;
    end
  end

  assign prdata   = prdata_q;
  assign pready   = pready_q;
  assign pslverr  = pslverr_q;
  assign spi_sck  = sck_q;
  assign spi_mosi = mosi_q;
  assign spi_ssn  = ssn_q;
  assign irq      = irq_q;
endmodule : sdc_top
`default_nettype wire

/* sim/sdc_spi_dev.sv */
`default_nettype none
// ==========================================================
// Serial slave on the far side: mode 0, MSB first
module sdc_spi_dev (
  input  wire logic       spi_sck,
  input  wire logic       spi_mosi,
  input  wire logic       spi_ssn,
  input  wire logic [7:0] reply,
  output logic            spi_miso,
  output logic      [7:0] got,
  output logic      [7:0] nbits
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  logic [7:0] rx;
  // First bit must stand before the first rising edge of the frame
  initial begin
    spi_miso = 1'b0;
    got = 8'h00;
    nbits = 8'h00;
  end
  always @(negedge spi_ssn) begin
    sh = reply;
    spi_miso = sh[7];
    nbits = 8'h00;
  end
  // Capture on rising edge, launch next bit on falling edge
  always @(posedge spi_sck) if (!spi_ssn) begin
    rx = {rx[6:0], spi_mosi};
    nbits = nbits + 8'h01;
  end
  always @(negedge spi_sck) if (!spi_ssn) begin
    sh = {sh[6:0], 1'b0};
    spi_miso = sh[7];
  end
  // Deselected: flip the line so stale samples fail
  always @(posedge spi_ssn) begin
    got = rx;
    spi_miso = ~spi_miso;
  end
endmodule : sdc_spi_dev
`default_nettype wire

/* sim/sdc_top_sva.sv */
`default_nettype none
// ==========================================================
// Port-level checker for the SPI data path
module sdc_top_sva (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        spi_sck,
  input  wire logic        spi_mosi,
  input  wire logic        spi_miso,
  input  wire logic        spi_ssn,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_ack,
  input  wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Access decode
  wire        acc    = psel && penable && pready;
  wire [15:0] idx    = paddr[17:2];
  wire        rd_acc = acc && !pwrite;
  wire        wr_ctl = acc && pwrite && pstrb[0] && (idx == sdc_pkg::IDX_CTRL);
  logic [1:0] poly_q;
  logic [2:0] len_q;
  logic [4:0] nrise_q;
  logic       sck_q;
  // Control shadow and clock rises per frame
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      poly_q <= 2'h0;
      len_q <= 3'h7;
      nrise_q <= 5'h00;
      sck_q <= 1'b0;
    end else begin
      sck_q <= spi_sck;
      if (wr_ctl) begin
        poly_q <= pwdata[5:4];
        len_q <= pwdata[2:0];
      end
      if (spi_ssn) nrise_q <= 5'h00;
      else if (spi_sck && !sck_q) nrise_q <= nrise_q + 5'h01;
    end
  end
  a_pready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered after one wait");
  a_pready_single: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  a_seven_bit_crc: assert property (rd_acc && idx == sdc_pkg::IDX_CRC_VAL &&
      poly_q == sdc_pkg::POLY_SEVEN |-> prdata[31:7] == 25'h0)
    else $error("seven bit checksum has high bits set");
  a_data_byte_low: assert property (rd_acc && idx == sdc_pkg::IDX_DATA |-> prdata[31:8] == 24'h0)
    else $error("data read carries bits above the byte");
  a_count_width: assert property (rd_acc && (idx == sdc_pkg::IDX_TX_LEN ||
      idx == sdc_pkg::IDX_RX_LEN) |-> prdata[31:11] == 21'h0)
    else $error("count read wider than eleven bits");
  a_base_width: assert property (rd_acc && (idx == sdc_pkg::IDX_TX_BASE ||
      idx == sdc_pkg::IDX_RX_BASE) |-> prdata[31:16] == 16'h0)
    else $error("base read wider than sixteen bits");
  a_clear_reads_zero: assert property (rd_acc && idx == sdc_pkg::IDX_CTRL |-> !prdata[7])
    else $error("checksum clear read back as one");
  a_frame_starts: assert property (acc && pwrite && idx == sdc_pkg::IDX_DATA && spi_ssn
      |-> ##[1:6] !spi_ssn)
    else $error("data write started no frame");
  a_frame_bits: assert property ($rose(spi_ssn) |-> nrise_q == 5'(len_q) + 5'h01)
    else $error("frame bit count differs from length field");
  a_sck_idle: assert property (spi_ssn |-> !spi_sck)
    else $error("serial clock moved outside a frame");
  a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
      && $stable(mem_we))
    else $error("memory request dropped or changed before ack");
endmodule : sdc_top_sva
`default_nettype wire

/* sim/tb_sdc_top.sv */
`default_nettype none
// ==========================================================
// Self-checking bench for the SPI data path
module tb_sdc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, v;
  logic [3:0] pstrb;
  logic spi_sck, spi_mosi, spi_miso, spi_ssn, irq, mem_req, mem_we, mem_ack;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata, reply, dev_got, dev_bits;
  logic [15:0] q_addr[$];
  logic [7:0] q_data[$];
  logic q_we[$];
  int err_total, n_tests, cyc, mem_lag, mwait;
  sdc_top i_dut (.*);
  sdc_spi_dev i_dev (.spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_ssn(spi_ssn),
    .reply(reply), .spi_miso(spi_miso), .got(dev_got), .nbits(dev_bits));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Memory model with lag; data flips while idle
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      end_of_test();
    end
    mem_ack <= mem_req && !mem_ack && mwait >= mem_lag;
    mem_rdata <= (mem_req && !mem_ack && mwait >= mem_lag) ? mem_addr[7:0] ^ 8'h55 : ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (mwait < mem_lag) mwait = mwait + 1;
      else begin
        mwait = 0;
        q_addr.push_back(mem_addr);
        q_we.push_back(mem_we);
        q_data.push_back(mem_wdata);
      end
    end
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] ix, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {14'h0, ix, 2'b00};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge mclk); while (pready !== 1'b1 && ++n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [15:0] ix, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, ix, d, r, e);
  endtask : wr
  task automatic rd(input logic [15:0] ix, output logic [31:0] r);
    logic e;
    apb(1'b0, ix, 32'h0, r, e);
  endtask : rd
  // Data is trusted only once the receive flag reads one
  task automatic xfer(input logic [7:0] d);
    logic [31:0] s;
    int n;
    wr(sdc_pkg::IDX_STATUS, 32'h1f);
    wr(sdc_pkg::IDX_DATA, {24'h0, d});
    n = 0;
    do rd(sdc_pkg::IDX_STATUS, s); while (s[0] !== 1'b1 && ++n < 100);
  endtask : xfer
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    chk(irq, 1);
  endtask : wait_irq
  // Bit-serial checksum reference, feeds the transmit stream MSB first
  function automatic logic [15:0] crc_ref(input logic [1:0] p, input logic [7:0] b);
    logic [15:0] c, t;
    logic fb;
    c = 16'hffff;
    t = (p == 2'h1) ? sdc_pkg::TAPS_SEVEN : (p == 2'h2) ? sdc_pkg::TAPS_ALT : sdc_pkg::TAPS_CCITT;
    for (int i = 7; i >= 0; i--) begin
      fb = ((p == 2'h1) ? c[6] : c[15]) ^ b[i];
      c = (c << 1) ^ (fb ? t : 16'h0);
    end
    return (p == 2'h1) ? (c & 16'h007f) : c;
  endfunction : crc_ref
  task automatic t_regs();
    logic [15:0] ix[4] = '{sdc_pkg::IDX_TX_BASE, sdc_pkg::IDX_TX_LEN,
                           sdc_pkg::IDX_RX_BASE, sdc_pkg::IDX_RX_LEN};
    logic [31:0] wv[4] = '{32'hffff, 32'h07ff, 32'ha5c3, 32'h0555};
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 4; i++) begin
      rd(ix[i], r);
      chk(r, 32'h0);
    end
    rd(sdc_pkg::IDX_CRC_VAL, r);
    chk(r, 32'hffff);
    for (int i = 0; i < 4; i++) wr(ix[i], wv[i]);
    for (int i = 0; i < 4; i++) begin
      rd(ix[i], r);
      chk(r, wv[i]);
    end
    wr(sdc_pkg::IDX_CRC_VAL, 32'h1234);
    rd(sdc_pkg::IDX_CRC_VAL, r);
    chk(r, 32'h1234);
    apb(1'b0, 16'hc0e0, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    $display("test regs done");
  endtask : t_regs
  task automatic t_byte();
    wr(sdc_pkg::IDX_CTRL, 32'h0607);
    wr(sdc_pkg::IDX_IRQ_MASK, 32'h0);
    reply = 8'hc3;
    xfer(8'h5a);
    chk(dev_got, 8'h5a);
    chk(dev_bits, 8'h08);
    chk(irq, 0);
    reply = 8'h3c;
    xfer(8'h11);
    wr(sdc_pkg::IDX_IRQ_MASK, 32'h1);
    repeat (3) @(posedge mclk);
    chk(irq, 1);
    rd(sdc_pkg::IDX_DATA, v);
    chk(v, 32'hc3);
    reply = 8'h69;
    xfer(8'h22);
    rd(sdc_pkg::IDX_DATA, v);
    chk(v, 32'h69);
    wr(sdc_pkg::IDX_STATUS, 32'h1f);
    repeat (3) @(posedge mclk);
    chk(irq, 0);
    wr(sdc_pkg::IDX_CTRL, 32'h0603);
    xfer(8'ha0);
    chk(dev_bits, 8'h04);
    rd(sdc_pkg::IDX_DATA, v);
    wr(sdc_pkg::IDX_CTRL, 32'h0607);
    $display("test byte done");
  endtask : t_byte
  task automatic t_crc();
    for (int p = 0; p < 4; p++) begin
      wr(sdc_pkg::IDX_CTRL, 32'h06c7 | (p << 4));
      rd(sdc_pkg::IDX_CTRL, v);
      chk(v[7], 0);
      rd(sdc_pkg::IDX_CRC_VAL, v);
      chk(v, (p == 1) ? 32'h7f : 32'hffff);
      xfer(8'h5a);
      rd(sdc_pkg::IDX_CRC_VAL, v);
      chk(v, {16'h0, crc_ref(2'(p), 8'h5a)});
      rd(sdc_pkg::IDX_DATA, v);
    end
    wr(sdc_pkg::IDX_CTRL, 32'h0607);
    $display("test crc done");
  endtask : t_crc
  task automatic t_dma();
    mem_lag = 3;
    q_addr.delete();
    q_we.delete();
    q_data.delete();
    wr(sdc_pkg::IDX_TX_BASE, 32'h0120);
    wr(sdc_pkg::IDX_TX_LEN, 32'h3);
    wr(sdc_pkg::IDX_STATUS, 32'h1f);
    wr(sdc_pkg::IDX_IRQ_MASK, 32'h4);
    wr(sdc_pkg::IDX_DMA_CMD, 32'h1);
    wait_irq();
    rd(sdc_pkg::IDX_STATUS, v);
    chk(v[2], 1);
    chk(q_addr.size(), 3);
    for (int i = 0; i < 3; i++) chk({q_we[i], q_addr[i]}, 17'h0120 + i);
    chk(dev_got, 8'h77);
    wr(sdc_pkg::IDX_STATUS, 32'h1f);
    rd(sdc_pkg::IDX_DATA, v);
    mem_lag = 0;
    reply = 8'h96;
    q_addr.delete();
    q_we.delete();
    q_data.delete();
    wr(sdc_pkg::IDX_RX_BASE, 32'h0240);
    wr(sdc_pkg::IDX_RX_LEN, 32'h2);
    wr(sdc_pkg::IDX_DMA_CMD, 32'h2);
    wait_irq();
    chk(q_addr.size(), 2);
    for (int i = 0; i < 2; i++) chk({q_we[i], q_data[i], q_addr[i]}, 25'h196_0240 + i);
    $display("test dma done");
  endtask : t_dma
  // Main sequence; reset for two cycles
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    mem_ack = 1'b0;
    mem_rdata = 8'h00;
    reply = 8'h00;
    {err_total, n_tests, cyc, mem_lag, mwait} = '0;
    resetn = 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_byte();
    t_crc();
    t_dma();
    end_of_test();
  end
endmodule : tb_sdc_top
bind sdc_top sdc_top_sva i_sva (.*);
`default_nettype wire
